/* bmem_top.v */
// Purpose: bank of block memory instances with AXI4-Lite setup registers
// Assumes: one clock mclk at 100 MHz, user ports synchronous to it
// Notes: each instance set as single port, dual port, simple dual port or fifo
//
// How it works
// - fourteen block memory instances, each used on its own.
// - each holds 4608 bits with registers before and after the array.
// - organisation per instance: single, true dual, simple dual port or fifo.
// - widths 1 to 36 bits; true dual port stops at 256 by 18.
// - contents may be preloaded over the bus before user operation runs.
// - address, data and controls are registered before the array access.
// - optional output register adds one stage after the array.
// - normal behaviour: only reads change the port output.
// - write-through: written value also appears on that port output.
// - read-before-write: old stored value appears while being replaced.
`timescale 1ns/100ps
`default_nettype none
`include "bmem_defines.vh"
module bmem_top
(
  // clock and reset
  input wire mclk,
  input wire rst_n,
  // axi4-lite register slave
  input wire [7:0] s_awaddr,
  input wire s_awvalid,
  output wire s_awready,
  input wire [31:0] s_wdata,
  input wire [3:0] s_wstrb,
  input wire s_wvalid,
  output wire s_wready,
  output wire [1:0] s_bresp,
  output wire s_bvalid,
  input wire s_bready,
  input wire [7:0] s_araddr,
  input wire s_arvalid,
  output wire s_arready,
  output wire [31:0] s_rdata,
  output wire [1:0] s_rresp,
  output wire s_rvalid,
  input wire s_rready,
  // port a of every instance, fifo write side
  input wire [`BMEM_NUM-1:0] a_en,
  input wire [`BMEM_NUM-1:0] a_we,
  input wire [`BMEM_NUM*`BMEM_AW-1:0] a_addr,
  input wire [`BMEM_NUM*`BMEM_DW-1:0] a_wdata,
  output wire [`BMEM_NUM*`BMEM_DW-1:0] a_rdata,
  output wire [`BMEM_NUM-1:0] a_full,
  // port b of every instance
  input wire [`BMEM_NUM-1:0] b_en,
  input wire [`BMEM_NUM-1:0] b_we,
  input wire [`BMEM_NUM*`BMEM_AW-1:0] b_addr,
  input wire [`BMEM_NUM*`BMEM_DW-1:0] b_wdata,
  output wire [`BMEM_NUM*`BMEM_DW-1:0] b_rdata,
  // fifo read stream of every instance
  output wire [`BMEM_NUM-1:0] q_valid,
  input wire [`BMEM_NUM-1:0] q_ready,
  output wire [`BMEM_NUM*`BMEM_DW-1:0] q_data
);

  ////////////////////////////////////////////////////////////////////////////
  // geometry helpers: row and bit offset of a word, and its width mask
  function [`BMEM_RW+5:0] geo;
    input [2:0] ratio;
    input [`BMEM_AW-1:0] ad;
    begin
      case (ratio)
        // lane offset six bits wide, 3*9 overflows four
        `BMEM_R_X1: geo = {ad[11:5], ad[4:3] * 6'd9 + {3'b0, ad[2:0]}};
        `BMEM_R_X2: geo = {ad[10:4], ad[3:2] * 6'd9 + {3'b0, ad[1:0], 1'b0}};
        `BMEM_R_X4: geo = {ad[9:3], ad[2:1] * 6'd9 + {3'b0, ad[0], 2'b0}};
        `BMEM_R_X9: geo = {ad[8:2], ad[1:0] * 6'd9};
        `BMEM_R_X18: geo = {ad[7:1], ad[0] ? 6'd18 : 6'd0};
        default: geo = {ad[6:0], 6'd0};
      endcase
    end
  endfunction

  function [`BMEM_DW-1:0] wmask;
    input [2:0] ratio;
    begin
      case (ratio)
        `BMEM_R_X1: wmask = 36'h000000001;
        `BMEM_R_X2: wmask = 36'h000000003;
        `BMEM_R_X4: wmask = 36'h00000000f;
        `BMEM_R_X9: wmask = 36'h0000001ff;
        `BMEM_R_X18: wmask = 36'h00003ffff;
        default: wmask = 36'hfffffffff;
      endcase
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // axi4-lite slave, one write and one read at a time
  reg awready_reg, wready_reg, bvalid_reg, arready_reg, rvalid_reg;
  reg aw_h_reg, w_h_reg;
  reg [7:0] awaddr_reg;
  reg [31:0] wdata_reg;
  reg [3:0] wstrb_reg;
  reg [1:0] bresp_reg, rresp_reg;
  reg [31:0] rdata_reg;
  reg run_reg;
  reg [31:0] ldsel_reg;
  reg [3:0] ldhi_reg;
  reg ld_we_reg;
  reg [3:0] ld_inst_reg;
  reg [`BMEM_RW-1:0] ld_row_reg;
  reg [`BMEM_DW-1:0] ld_data_reg;
  reg [7:0] cfg_reg [0:`BMEM_NUM-1];
  wire [`BMEM_NUM-1:0] st_empty, st_full, st_bad;
  wire [`BMEM_NUM*`BMEM_CW-1:0] st_cnt;
  wire aw_take = s_awvalid & awready_reg;
  wire w_take = s_wvalid & wready_reg;
  wire ar_take = s_arvalid & arready_reg;
  wire do_wr = aw_h_reg & w_h_reg & ~bvalid_reg;
  wire aw_h_next = (aw_h_reg & ~do_wr) | aw_take;
  wire w_h_next = (w_h_reg & ~do_wr) | w_take;
  wire bvalid_next = (bvalid_reg & ~s_bready) | do_wr;
  wire rvalid_next = (rvalid_reg & ~s_rready) | ar_take;
  wire [31:0] bmask = {{8{wstrb_reg[3]}}, {8{wstrb_reg[2]}}, {8{wstrb_reg[1]}}, {8{wstrb_reg[0]}}};
  wire [31:0] ctrl_new = ({31'b0, run_reg} & ~bmask) | (wdata_reg & bmask);
  wire [31:0] ldsel_new = (ldsel_reg & ~bmask) | (wdata_reg & bmask);
  wire [3:0] wr_idx = awaddr_reg[5:2];
  wire [3:0] rd_idx = s_araddr[5:2];
  wire wr_cfg = (awaddr_reg[7:6] == `BMEM_CFG_PAGE) && (wr_idx < `BMEM_NUM) && (awaddr_reg[1:0] == 2'b00);
  wire wr_known = wr_cfg || awaddr_reg == `BMEM_OFF_CTRL || awaddr_reg == `BMEM_OFF_LDSEL
    || awaddr_reg == `BMEM_OFF_LDHI || awaddr_reg == `BMEM_OFF_LDLO;
  reg [31:0] rd_val;
  reg rd_ok;
  integer k;

  assign s_awready = awready_reg;
  assign s_wready = wready_reg;
  assign s_bvalid = bvalid_reg;
  assign s_bresp = bresp_reg;
  assign s_arready = arready_reg;
  assign s_rvalid = rvalid_reg;
  assign s_rresp = rresp_reg;
  assign s_rdata = rdata_reg;

  always @*
  begin
    rd_val = 32'h00000000;
    rd_ok = 1'b1;
    if (s_araddr == `BMEM_OFF_CTRL)
      rd_val = {31'b0, run_reg};
    else if (s_araddr == `BMEM_OFF_LDSEL)
      rd_val = ldsel_reg;
    else if (s_araddr == `BMEM_OFF_LDHI)
      rd_val = {28'b0, ldhi_reg};
    else if (s_araddr == `BMEM_OFF_LDLO)
      rd_val = 32'h00000000;
    else if (s_araddr[1:0] == 2'b00 && rd_idx < `BMEM_NUM && s_araddr[7:6] == `BMEM_CFG_PAGE)
      rd_val = {24'b0, cfg_reg[rd_idx]};
    else if (s_araddr[1:0] == 2'b00 && rd_idx < `BMEM_NUM && s_araddr[7:6] == `BMEM_STAT_PAGE)
    begin
      rd_val[`BMEM_STAT_EMPTY] = st_empty[rd_idx];
      rd_val[`BMEM_STAT_FULL] = st_full[rd_idx];
      rd_val[`BMEM_STAT_BAD] = st_bad[rd_idx];
      rd_val[`BMEM_STAT_CNT] = st_cnt[rd_idx*`BMEM_CW +: `BMEM_CW];
    end
    else
      rd_ok = 1'b0;
  end

  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      awready_reg <= 1'b0;
      wready_reg <= 1'b0;
      arready_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      rvalid_reg <= 1'b0;
      aw_h_reg <= 1'b0;
      w_h_reg <= 1'b0;
      awaddr_reg <= 8'h00;
      wdata_reg <= 32'h00000000;
      wstrb_reg <= 4'h0;
      bresp_reg <= `BMEM_RESP_OKAY;
      rresp_reg <= `BMEM_RESP_OKAY;
      rdata_reg <= 32'h00000000;
      run_reg <= 1'b0;
      ldsel_reg <= 32'h00000000;
      ldhi_reg <= 4'h0;
      ld_we_reg <= 1'b0;
      ld_inst_reg <= 4'h0;
      ld_row_reg <= {`BMEM_RW{1'b0}};
      ld_data_reg <= {`BMEM_DW{1'b0}};
      for (k = 0; k < `BMEM_NUM; k = k + 1)
        cfg_reg[k] <= `BMEM_CFG_RST;
    end
    else
    begin
      awready_reg <= ~aw_h_next;
      wready_reg <= ~w_h_next;
      arready_reg <= ~rvalid_next;
      aw_h_reg <= aw_h_next;
      w_h_reg <= w_h_next;
      bvalid_reg <= bvalid_next;
      rvalid_reg <= rvalid_next;
      ld_we_reg <= 1'b0;
      if (aw_take)
        awaddr_reg <= s_awaddr;
      if (w_take)
      begin
        wdata_reg <= s_wdata;
        wstrb_reg <= s_wstrb;
      end
      if (ar_take)
      begin
        rdata_reg <= rd_val;
        rresp_reg <= rd_ok ? `BMEM_RESP_OKAY : `BMEM_RESP_SLVERR;
      end
      if (do_wr)
      begin
        bresp_reg <= wr_known ? `BMEM_RESP_OKAY : `BMEM_RESP_SLVERR;
        if (awaddr_reg == `BMEM_OFF_CTRL)
          run_reg <= ctrl_new[`BMEM_CTRL_RUN];
        if (awaddr_reg == `BMEM_OFF_LDSEL)
          ldsel_reg <= ldsel_new & 32'h00000f7f;
        if (awaddr_reg == `BMEM_OFF_LDHI && wstrb_reg[0])
          ldhi_reg <= wdata_reg[3:0];
        if (wr_cfg && wstrb_reg[0])
          cfg_reg[wr_idx] <= wdata_reg[7:0];
        if (awaddr_reg == `BMEM_OFF_LDLO && !run_reg)
        begin
          ld_we_reg <= 1'b1;
          ld_inst_reg <= ldsel_reg[`BMEM_LDSEL_INST];
          ld_row_reg <= ldsel_reg[`BMEM_LDSEL_ROW];
          ld_data_reg <= {ldhi_reg, wdata_reg};
          ldsel_reg[`BMEM_LDSEL_ROW] <= ldsel_reg[`BMEM_LDSEL_ROW] + 7'd1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // memory instances
  genvar g;
  generate
    for (g = 0; g < `BMEM_NUM; g = g + 1)
    begin : inst
      reg [`BMEM_DW-1:0] mem [0:`BMEM_ROWS-1];
      reg en0_reg, we0_reg, en1_reg, we1_reg;
      reg [`BMEM_AW-1:0] ad0_reg, ad1_reg, wptr_reg, rptr_reg;
      reg [`BMEM_DW-1:0] wd0_reg, wd1_reg;
      reg [`BMEM_DW-1:0] s1d0_reg, s1d1_reg, out0_reg, out1_reg, fq_reg;
      reg s1v0_reg, s1v1_reg, infl_reg, full_reg;
      reg [`BMEM_CW-1:0] cnt_reg;
      wire [1:0] mode = cfg_reg[g][`BMEM_CFG_MODE];
      wire [2:0] ratio = cfg_reg[g][`BMEM_CFG_RATIO];
      wire [1:0] wbeh = cfg_reg[g][`BMEM_CFG_WBEH];
      wire oreg = cfg_reg[g][`BMEM_CFG_OREG];
      wire fifo = (mode == `BMEM_MODE_FIFO);
      wire bad = (ratio > `BMEM_R_X36) || (mode == `BMEM_MODE_TDP && ratio == `BMEM_R_X36);
      wire act = run_reg & ~bad;
      wire b_used = (mode == `BMEM_MODE_TDP) || (mode == `BMEM_MODE_PDP);
      wire [`BMEM_DW-1:0] m = wmask(ratio);
      wire [`BMEM_CW-1:0] depth = `BMEM_FULL_DEPTH >> ratio;
      wire [`BMEM_AW-1:0] pmask = depth[`BMEM_AW-1:0] - 12'h001;
      wire [`BMEM_RW+5:0] g0 = geo(ratio, fifo ? wptr_reg : ad0_reg);
      wire [`BMEM_RW+5:0] g1 = geo(ratio, fifo ? rptr_reg : ad1_reg);
      wire [`BMEM_RW-1:0] row0 = g0[`BMEM_RW+5:6];
      wire [`BMEM_RW-1:0] row1 = g1[`BMEM_RW+5:6];
      wire [`BMEM_DW-1:0] old0 = (mem[row0] >> g0[5:0]) & m;
      wire [`BMEM_DW-1:0] old1 = (mem[row1] >> g1[5:0]) & m;
      // drop pushes when full and reads when empty
      wire push = fifo & en0_reg & we0_reg & ~full_reg;
      wire buf_rdy;
      wire rd_issue = fifo & act & (cnt_reg != {`BMEM_CW{1'b0}}) & ~infl_reg & buf_rdy;
      wire wr0 = ~fifo & en0_reg & we0_reg;
      wire wr1 = ~fifo & en1_reg & we1_reg;
      wire [`BMEM_DW-1:0] base1 = (wr0 && row0 == row1) ? ((mem[row0] & ~(m << g0[5:0]))
        | ((wd0_reg & m) << g0[5:0])) : mem[row1];
      wire [`BMEM_DW-1:0] nv0 = (mem[row0] & ~(m << g0[5:0])) | ((wd0_reg & m) << g0[5:0]);
      wire [`BMEM_DW-1:0] nv1 = (base1 & ~(m << g1[5:0])) | ((wd1_reg & m) << g1[5:0]);
      wire ld0 = ~fifo & en0_reg & (~we0_reg | wbeh != `BMEM_WB_NORMAL);
      wire ld1 = ~fifo & en1_reg & (~we1_reg | wbeh != `BMEM_WB_NORMAL);
      wire [`BMEM_DW-1:0] v0 = (we0_reg && wbeh == `BMEM_WB_THROUGH) ? (wd0_reg & m) : old0;
      wire [`BMEM_DW-1:0] v1 = (we1_reg && wbeh == `BMEM_WB_THROUGH) ? (wd1_reg & m) : old1;
      wire [`BMEM_CW-1:0] cnt_next = cnt_reg + {12'b0, push} - {12'b0, rd_issue};

      always @(posedge mclk)
      begin
        if (ld_we_reg && ld_inst_reg == g)
          mem[ld_row_reg] <= ld_data_reg;
        else
        begin
          if (wr0 || push)
            mem[row0] <= nv0;
          if (wr1)
            mem[row1] <= nv1;
        end
      end

      always @(posedge mclk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          en0_reg <= 1'b0;
          we0_reg <= 1'b0;
          en1_reg <= 1'b0;
          we1_reg <= 1'b0;
          ad0_reg <= {`BMEM_AW{1'b0}};
          ad1_reg <= {`BMEM_AW{1'b0}};
          wd0_reg <= {`BMEM_DW{1'b0}};
          wd1_reg <= {`BMEM_DW{1'b0}};
          s1v0_reg <= 1'b0;
          s1v1_reg <= 1'b0;
          s1d0_reg <= {`BMEM_DW{1'b0}};
          s1d1_reg <= {`BMEM_DW{1'b0}};
          out0_reg <= {`BMEM_DW{1'b0}};
          out1_reg <= {`BMEM_DW{1'b0}};
          wptr_reg <= {`BMEM_AW{1'b0}};
          rptr_reg <= {`BMEM_AW{1'b0}};
          cnt_reg <= {`BMEM_CW{1'b0}};
          full_reg <= 1'b0;
          infl_reg <= 1'b0;
          fq_reg <= {`BMEM_DW{1'b0}};
        end
        else
        begin
          en0_reg <= a_en[g] & act & (mode != `BMEM_MODE_PDP | a_we[g]);
          we0_reg <= a_we[g];
          en1_reg <= b_en[g] & act & b_used;
          we1_reg <= b_we[g] & (mode == `BMEM_MODE_TDP);
          ad0_reg <= a_addr[g*`BMEM_AW +: `BMEM_AW];
          ad1_reg <= b_addr[g*`BMEM_AW +: `BMEM_AW];
          wd0_reg <= a_wdata[g*`BMEM_DW +: `BMEM_DW];
          wd1_reg <= b_wdata[g*`BMEM_DW +: `BMEM_DW];
          s1v0_reg <= ld0;
          s1v1_reg <= ld1;
          s1d0_reg <= v0;
          s1d1_reg <= v1;
          // one or two cycle read latency
          if (oreg ? s1v0_reg : ld0)
            out0_reg <= oreg ? s1d0_reg : v0;
          if (oreg ? s1v1_reg : ld1)
            out1_reg <= oreg ? s1d1_reg : v1;
          // pointers wrap at depth, order kept
          if (!fifo)
          begin
            wptr_reg <= {`BMEM_AW{1'b0}};
            rptr_reg <= {`BMEM_AW{1'b0}};
            cnt_reg <= {`BMEM_CW{1'b0}};
            full_reg <= 1'b0;
          end
          else
          begin
            if (push)
              wptr_reg <= (wptr_reg + 12'h001) & pmask;
            if (rd_issue)
              rptr_reg <= (rptr_reg + 12'h001) & pmask;
            cnt_reg <= cnt_next;
            full_reg <= (cnt_next == depth);
          end
          infl_reg <= rd_issue;
          fq_reg <= old1;
        end
      end

      bmem_skid u_skid
      (
        .mclk(mclk),
        .rst_n(rst_n),
        .in_valid(infl_reg),
        .in_ready(buf_rdy),
        .in_data(fq_reg),
        .out_valid(q_valid[g]),
        .out_ready(q_ready[g]),
        .out_data(q_data[g*`BMEM_DW +: `BMEM_DW])
      );

      assign a_rdata[g*`BMEM_DW +: `BMEM_DW] = out0_reg;
      assign b_rdata[g*`BMEM_DW +: `BMEM_DW] = out1_reg;
      assign a_full[g] = full_reg;
      assign st_full[g] = full_reg;
      assign st_empty[g] = (cnt_reg == {`BMEM_CW{1'b0}});
      assign st_bad[g] = bad;
      assign st_cnt[g*`BMEM_CW +: `BMEM_CW] = cnt_reg;
    end
  endgenerate
endmodule // bmem_top
`default_nettype wire

/* bmem_defines.vh */
// Purpose: shared constants of the block memory bank
// Assumes: included by bmem_top.v and bmem_skid.v
// Notes: definitions only
`ifndef BMEM_DEFINES_VH
`define BMEM_DEFINES_VH
// bank geometry
`define BMEM_NUM 14
`define BMEM_AW 12
`define BMEM_DW 36
`define BMEM_ROWS 128
`define BMEM_RW 7
`define BMEM_CW 13
`define BMEM_LANE 9
// register byte offsets and address page codes
`define BMEM_OFF_CTRL 8'h00
`define BMEM_OFF_LDSEL 8'h04
`define BMEM_OFF_LDHI 8'h08
`define BMEM_OFF_LDLO 8'h0c
`define BMEM_CFG_PAGE 2'h1
`define BMEM_STAT_PAGE 2'h2
// field positions
`define BMEM_CTRL_RUN 0
`define BMEM_LDSEL_INST 11:8
`define BMEM_LDSEL_ROW 6:0
`define BMEM_CFG_MODE 1:0
`define BMEM_CFG_RATIO 4:2
`define BMEM_CFG_WBEH 6:5
`define BMEM_CFG_OREG 7
`define BMEM_STAT_EMPTY 0
`define BMEM_STAT_FULL 1
`define BMEM_STAT_BAD 2
`define BMEM_STAT_CNT 28:16
// organisations
`define BMEM_MODE_SP 2'h0
`define BMEM_MODE_TDP 2'h1
`define BMEM_MODE_PDP 2'h2
`define BMEM_MODE_FIFO 2'h3
// width ratios, code r means 4096 >> r words
`define BMEM_R_X1 3'h0
`define BMEM_R_X2 3'h1
`define BMEM_R_X4 3'h2
`define BMEM_R_X9 3'h3
`define BMEM_R_X18 3'h4
`define BMEM_R_X36 3'h5
`define BMEM_FULL_DEPTH 13'h1000
// write behaviours
`define BMEM_WB_NORMAL 2'h0
`define BMEM_WB_THROUGH 2'h1
`define BMEM_WB_RBW 2'h2
// reset values and responses
`define BMEM_CFG_RST 8'h00
`define BMEM_RESP_OKAY 2'h0
`define BMEM_RESP_SLVERR 2'h2
`endif

/* bmem_skid.v */
// Purpose: two-entry buffer with valid and ready on both sides
// Assumes: single clock mclk, asynchronous active-low reset
// Notes: output side comes straight from flops
`timescale 1ns/100ps
`default_nettype none
`include "bmem_defines.vh"
module bmem_skid
(
  // clock and reset
  input wire mclk,
  input wire rst_n,
  // fill side
  input wire in_valid,
  output wire in_ready,
  input wire [`BMEM_DW-1:0] in_data,
  // drain side
  output wire out_valid,
  input wire out_ready,
  output wire [`BMEM_DW-1:0] out_data
);
  reg head_v_reg;
  reg tail_v_reg;
  reg [`BMEM_DW-1:0] head_reg;
  reg [`BMEM_DW-1:0] tail_reg;
  wire pop;
  wire push;

  assign in_ready = ~tail_v_reg;
  assign out_valid = head_v_reg;
  assign out_data = head_reg;
  assign pop = head_v_reg & out_ready;
  assign push = in_valid & in_ready;

  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      head_v_reg <= 1'b0;
      tail_v_reg <= 1'b0;
      head_reg <= {`BMEM_DW{1'b0}};
      tail_reg <= {`BMEM_DW{1'b0}};
    end
    else if (!head_v_reg || pop)
    begin
      if (tail_v_reg)
      begin
        head_reg <= tail_reg;
        head_v_reg <= 1'b1;
        tail_v_reg <= push;
        tail_reg <= in_data;
      end
      else
      begin
        head_v_reg <= push;
        head_reg <= in_data;
      end
    end
    else if (push)
    begin
      tail_v_reg <= 1'b1;
      tail_reg <= in_data;
    end
  end
endmodule // bmem_skid
`default_nettype wire

/* bmem_checker.sv */
// Purpose: concurrent checks on the block memory bank ports
// Assumes: one clock mclk, rst_n asynchronous active low
// Notes: bound to bmem_top below the module
`timescale 1ns/100ps
`default_nettype none
`include "bmem_defines.vh"
module bmem_checker
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // register bus
  input wire logic s_awvalid,
  input wire logic s_awready,
  input wire logic s_wvalid,
  input wire logic s_wready,
  input wire logic [1:0] s_bresp,
  input wire logic s_bvalid,
  input wire logic s_bready,
  input wire logic s_arvalid,
  input wire logic s_arready,
  input wire logic [31:0] s_rdata,
  input wire logic s_rvalid,
  input wire logic s_rready,
  // user ports
  input wire logic [`BMEM_NUM-1:0] a_en,
  input wire logic [`BMEM_NUM*`BMEM_DW-1:0] a_rdata,
  input wire logic [`BMEM_NUM-1:0] a_full,
  input wire logic [`BMEM_NUM-1:0] b_en,
  input wire logic [`BMEM_NUM*`BMEM_DW-1:0] b_rdata,
  input wire logic [`BMEM_NUM-1:0] q_valid,
  input wire logic [`BMEM_NUM-1:0] q_ready
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////////////////////
  a_ready_after_reset: assert property ($rose(rst_n) |=> s_awready && s_wready && s_arready)
    else $error("bus readies not raised after reset");
  a_aw_slot_busy: assert property (s_awvalid && s_awready |=> !s_awready)
    else $error("write address accepted twice in a row");
  a_write_resp_time: assert property (s_awvalid && s_awready && s_wvalid && s_wready && !s_bvalid
    |-> ##1 !s_bvalid ##1 s_bvalid) else $error("write response not two edges after take");
  a_read_resp_time: assert property (s_arvalid && s_arready && !s_rvalid |=> s_rvalid)
    else $error("read response not one edge after take");
  a_bresp_held: assert property (s_bvalid && !s_bready |=> s_bvalid && $stable(s_bresp))
    else $error("write response dropped before taken");
  a_rdata_held: assert property (s_rvalid && !s_rready |=> s_rvalid && $stable(s_rdata))
    else $error("read response dropped before taken");
  a_stream_held: assert property ((q_valid & ~q_ready) != '0
    |=> (q_valid & $past(q_valid & ~q_ready)) == $past(q_valid & ~q_ready)) else $error("stream word withdrawn");
  a_idle_output_held: assert property ((a_en == '0 && b_en == '0) [*3]
    |=> $stable(a_rdata) && $stable(b_rdata)) else $error("read output moved without access");
  c_write_done: cover property (s_bvalid && s_bready);
  c_stream_pop: cover property (q_valid[3] && q_ready[3]);
  c_fifo_full: cover property (a_full[3]);
endmodule // bmem_checker

bind bmem_top bmem_checker u_bmem_checker (.mclk(mclk), .rst_n(rst_n), .s_awvalid(s_awvalid),
  .s_awready(s_awready), .s_wvalid(s_wvalid), .s_wready(s_wready), .s_bresp(s_bresp), .s_bvalid(s_bvalid),
  .s_bready(s_bready), .s_arvalid(s_arvalid), .s_arready(s_arready), .s_rdata(s_rdata), .s_rvalid(s_rvalid),
  .s_rready(s_rready), .a_en(a_en), .a_rdata(a_rdata), .a_full(a_full), .b_en(b_en), .b_rdata(b_rdata),
  .q_valid(q_valid), .q_ready(q_ready));
`default_nettype wire

/* bmem_user_model.sv */
// Purpose: fabric logic draining one fifo read stream
// Assumes: same clock as the bank
// Notes: stall holds ready low so the fifo can fill
`timescale 1ns/100ps
`default_nettype none
module bmem_user_model
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // control from bench
  input wire logic stall,
  // fifo read stream
  input wire logic q_valid,
  input wire logic [35:0] q_data,
  output var logic q_ready
);
  logic [35:0] rxq [$];
  integer pseed = 7;
  // random back-pressure, words kept in arrival order
  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      q_ready <= 1'b0;
    else
    begin
      if (q_valid && q_ready)
        rxq.push_back(q_data);
      q_ready <= !stall && (($random(pseed) & 1) == 1);
    end
  end
endmodule // bmem_user_model
`default_nettype wire

/* embedded_block_ram_tb_top.sv */
// Purpose: self-checking bench of the block memory bank
// Assumes: 100 MHz mclk, all instances set to 36 or 18 bit widths
// Notes: seed 90, expectations from a bench-side memory image
`timescale 1ns/100ps
`default_nettype none
`include "bmem_defines.vh"
module embedded_block_ram_tb_top;
  localparam logic [1:0] OK = `BMEM_RESP_OKAY;
  localparam logic [1:0] ER = `BMEM_RESP_SLVERR;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] s_awaddr = 8'h00, s_araddr = 8'h00;
  logic [31:0] s_wdata = 32'h0;
  logic [3:0] s_wstrb = 4'hf;
  logic s_awvalid = 1'b0, s_wvalid = 1'b0, s_bready = 1'b0, s_arvalid = 1'b0, s_rready = 1'b0;
  wire s_awready, s_wready, s_arready, s_bvalid, s_rvalid, pq;
  wire [1:0] s_bresp, s_rresp;
  wire [31:0] s_rdata;
  logic [13:0] a_en = 14'h0, a_we = 14'h0, b_en = 14'h0, b_we = 14'h0;
  logic [167:0] a_addr = 168'h0, b_addr = 168'h0;
  logic [503:0] a_wdata = 504'h0, b_wdata = 504'h0;
  wire [503:0] a_rdata, b_rdata, q_data;
  wire [13:0] a_full, q_valid;
  logic stall = 1'b1;
  integer seed = 90, fail_count = 0, checked = 0, g, r, i, n;
  integer pk [0:4] = '{0, 1, 2, 4, 13};
  logic [35:0] m [0:13][0:3];
  logic [35:0] o [0:13];
  logic [35:0] pushed [$];
  logic [7:0] cf [0:13];
  logic [63:0] rv;
  logic [31:0] rd;
  initial forever #5 mclk = ~mclk;
  bmem_top u_bmem_top (.mclk(mclk), .rst_n(rst_n), .s_awaddr(s_awaddr), .s_awvalid(s_awvalid),
    .s_awready(s_awready), .s_wdata(s_wdata), .s_wstrb(s_wstrb), .s_wvalid(s_wvalid), .s_wready(s_wready),
    .s_bresp(s_bresp), .s_bvalid(s_bvalid), .s_bready(s_bready), .s_araddr(s_araddr), .s_arvalid(s_arvalid),
    .s_arready(s_arready), .s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid), .s_rready(s_rready),
    .a_en(a_en), .a_we(a_we), .a_addr(a_addr), .a_wdata(a_wdata), .a_rdata(a_rdata), .a_full(a_full),
    .b_en(b_en), .b_we(b_we), .b_addr(b_addr), .b_wdata(b_wdata), .b_rdata(b_rdata), .q_valid(q_valid),
    .q_ready({10'h0, pq, 3'h0}), .q_data(q_data));
  bmem_user_model u_bmem_user_model (.mclk(mclk), .rst_n(rst_n), .stall(stall), .q_valid(q_valid[3]),
    .q_data(q_data[143:108]), .q_ready(pq));
  ////////////////////////////////////////////////////////////////////////////
  task chk(input logic [63:0] got, input logic [63:0] exp);
    checked = checked + 1;
    if (got !== exp)
    begin
      fail_count = fail_count + 1;
      $display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task final_report;
    if (fail_count == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task axw(input logic [7:0] ad, input logic [31:0] d, input logic [1:0] er);
    @(posedge mclk);
    s_awaddr <= ad;
    s_wdata <= d;
    s_awvalid <= 1'b1;
    s_wvalid <= 1'b1;
    s_bready <= 1'b1;
    do
    begin
      @(posedge mclk);
      if (s_awready)
        s_awvalid <= 1'b0;
      if (s_wready)
        s_wvalid <= 1'b0;
    end
    while (!s_bvalid);
    s_bready <= 1'b0;
    chk(s_bresp, er);
  endtask
  task axr(input logic [7:0] ad, input logic [1:0] er, output logic [31:0] d);
    @(posedge mclk);
    s_araddr <= ad;
    s_arvalid <= 1'b1;
    s_rready <= 1'b1;
    do
    begin
      @(posedge mclk);
      if (s_arready)
        s_arvalid <= 1'b0;
    end
    while (!s_rvalid);
    d = s_rdata;
    s_rready <= 1'b0;
    chk(s_rresp, er);
  endtask
  // expected port output after an access
  function automatic logic [35:0] expo(input integer k, input logic we, input logic [35:0] old, d);
    expo = old;
    if (we && cf[k][6:5] == `BMEM_WB_THROUGH)
      expo = d;
    else if (we && cf[k][6:5] != `BMEM_WB_RBW)
      expo = o[k];
    if (cf[k][1:0] == `BMEM_MODE_TDP && cf[k][4:2] == `BMEM_R_X36)
      expo = o[k];
  endfunction
  task op(input integer k, input logic we, input logic [1:0] ra, input logic [35:0] d);
    logic pb;
    logic [35:0] e;
    pb = (k == 4 || k == 13);
    if (cf[k][4:2] == `BMEM_R_X18)
      d = d & 36'h3ffff;
    e = expo(k, we, m[k][ra], d);
    @(posedge mclk);
    if (pb && !we)
    begin
      b_en[k] <= 1'b1;
      b_addr[k*12+:12] <= {10'h0, ra};
    end
    else
    begin
      a_en[k] <= 1'b1;
      a_we[k] <= we;
      a_addr[k*12+:12] <= {10'h0, ra};
      a_wdata[k*36+:36] <= d;
    end
    @(posedge mclk);
    a_en <= 14'h0;
    b_en <= 14'h0;
    if (we)
      m[k][ra] = d;
    repeat (cf[k][7] ? 2 : 1)
    begin
      #1 chk(pb ? b_rdata[k*36+:36] : a_rdata[k*36+:36], o[k]);
      @(posedge mclk);
    end
    #1 chk(pb ? b_rdata[k*36+:36] : a_rdata[k*36+:36], e);
    o[k] = e;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (6) @(posedge mclk);
    chk({a_full, q_valid}, 0);
    rst_n <= 1'b1;
    repeat (2) @(posedge mclk);
    for (g = 0; g < 14; g = g + 1)
      cf[g] = 8'h14;
    cf[1] = 8'hb4;
    cf[2] = 8'h54;
    cf[3] = 8'h17;
    cf[4] = 8'h16;
    cf[5] = 8'h15;
    cf[13] = 8'h11;
    for (g = 0; g < 14; g = g + 1)
    begin
      o[g] = 36'h0;
      axw(8'(8'h40 + 4 * g), {24'h0, cf[g]}, OK);
      axw(8'h04, g << 8, OK);
      for (r = 0; r < 4; r = r + 1)
      begin
        rv = {$random(seed), $random(seed)};
        m[g][r] = rv[35:0];
        axw(8'h08, {28'h0, rv[35:32]}, OK);
        axw(8'h0c, rv[31:0], OK);
      end
    end
    axr(8'h44, OK, rd);
    chk(rd, 32'hb4);
    axr(8'h94, OK, rd);
    chk(rd[2], 1'b1);
    axr(8'h8c, OK, rd);
    chk(rd[1:0], 2'b01);
    axr(8'h0c, OK, rd);
    chk(rd, 0);
    axw(8'hfc, 32'h1, ER);
    axr(8'hfc, ER, rd);
    chk(rd, 0);
    axw(8'h00, 32'h1, OK);
    axw(8'h04, 32'h0, OK);
    axw(8'h0c, ~m[0][0][31:0], OK);
    for (g = 6; g < 13; g = g + 1)
      a_addr[g*12+:12] <= 12'h002;
    a_en <= 14'h1fc0;
    @(posedge mclk);
    a_en <= 14'h0;
    @(posedge mclk);
    #1;
    for (g = 6; g < 13; g = g + 1)
    begin
      chk(a_rdata[g*36+:36], m[g][2]);
      o[g] = m[g][2];
    end
    op(0, 1'b0, 2'd0, 36'h0);
    for (r = 0; r < 4; r = r + 1)
      op(13, 1'b1, r[1:0], {18'h0, 18'h2a5a5 ^ 18'(r)});
    for (i = 0; i < 5; i = i + 1)
    begin
      op(pk[i], 1'b1, 2'd1, 36'hc3a5f0963);
      op(pk[i], 1'b0, 2'd1, 36'h0);
    end
    repeat (80)
    begin
      g = pk[($random(seed) & 32'h7fffffff) % 5];
      rv = {$random(seed), $random(seed)};
      op(g, rv[40], rv[45:44], rv[35:0] & (g == 13 ? 36'h3ffff : 36'hfffffffff));
    end
    op(5, 1'b0, 2'd0, 36'h0);
    @(posedge mclk);
    for (i = 0; i < 134; i = i + 1)
    begin
      rv = {$random(seed), $random(seed)};
      a_en[3] <= 1'b1;
      a_we[3] <= 1'b1;
      a_wdata[143:108] <= rv[35:0];
      pushed.push_back(rv[35:0]);
      @(posedge mclk);
    end
    a_en <= 14'h0;
    repeat (4) @(posedge mclk);
    chk(a_full[3], 1'b1);
    stall <= 1'b0;
    n = 0;
    i = 0;
    while (i < 2 && n < 400)
    begin
      axr(8'h8c, OK, rd);
      i = (rd[0] && !q_valid[3]) ? i + 1 : 0;
      n = n + 1;
    end
    chk(u_bmem_user_model.rxq.size() >= 128, 1'b1);
    for (i = 0; i < u_bmem_user_model.rxq.size(); i = i + 1)
      chk(u_bmem_user_model.rxq[i], pushed[i]);
    chk({a_full[3], rd[1:0]}, 3'b001);
    final_report;
  end
  initial
  begin
    repeat (20000) @(posedge mclk);
    fail_count = fail_count + 1;
    final_report;
  end
endmodule // embedded_block_ram_tb_top
`default_nettype wire
